/* File: include/ref_switch_defines.svh */
// timing counts, reset values and field widths for the reference switchover block
`ifndef REF_SWITCH_DEFINES_SVH
`define REF_SWITCH_DEFINES_SVH
`define REF_DIV_WIDTH 10
`define REF_DIV_MAX 10'h03FF
`define REF_DIV_RESET 10'h0001
`define CLK_PERIOD_NS 5
`define MON_WINDOW_NS 2560
`define MON_WINDOW_CYC ((`MON_WINDOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MON_CNT_WIDTH 10
`endif

/* File: include/ref_switch_pkg.sv */
// types shared by the reference switchover block
package ref_switch_pkg;
  typedef enum logic [1:0] {
    SEL_PRIMARY,
    SEL_SECONDARY,
    SEL_HOLDOVER
  } sel_state_e;
endpackage

/* File: core/ref_divider.sv */
// integer reference divider with presence monitor for one reference input
`timescale 1ns/100ps
`default_nettype none
`include "ref_switch_defines.svh"
module ref_divider (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // reference sample and setting
  input wire logic ref_in,
  input wire logic enable_in,
  input wire logic [`REF_DIV_WIDTH-1:0] ratio_in,
  // divided pulse and presence
  output logic div_pulse_out,
  output logic present_out
);
  logic ref_d;
  logic [`REF_DIV_WIDTH-1:0] cnt;
  logic [`MON_CNT_WIDTH-1:0] mon;
  logic next_ref_d;
  logic [`REF_DIV_WIDTH-1:0] next_cnt;
  logic [`MON_CNT_WIDTH-1:0] next_mon;
  logic next_div_pulse;
  logic next_present;
  logic rise;

  // divide rising edges by ratio, zero treated as one; watchdog clears presence
  always_comb begin
    rise = ref_in & ~ref_d & enable_in;
    next_ref_d = ref_in;
    next_cnt = cnt;
    next_div_pulse = 1'b0;
    next_mon = mon;
    next_present = present_out;
    if (rise) begin
      next_mon = '0;
      next_present = 1'b1;
      if (cnt + 10'h0001 >= ratio_in) begin
        next_cnt = '0;
        next_div_pulse = 1'b1;
      end else begin
        next_cnt = cnt + 10'h0001;
      end
    end else if (mon == `MON_CNT_WIDTH'(`MON_WINDOW_CYC - 1) || !enable_in) begin
      next_present = 1'b0;
      next_mon = '0;
    end else begin
      next_mon = mon + 10'h001;
    end
  end

  // state registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ref_d <= 1'b0;
      cnt <= '0;
      mon <= '0;
      div_pulse_out <= 1'b0;
      present_out <= 1'b0;
    end else begin
      ref_d <= next_ref_d;
      cnt <= next_cnt;
      mon <= next_mon;
      div_pulse_out <= next_div_pulse;
      present_out <= next_present;
    end
  end
endmodule
`default_nettype wire

/* File: core/ref_switchover_holdover_ctrl.sv */
// reference selection, switchover, holdover and receiver power control
// Operation
// - each reference gets a 1..1023 divider
// - monitor both references, feed selection logic
// - manual selection by setting or pin
// - automatic mode prefers primary, falls to secondary
// - nonrevertive stays on secondary until it fails
// - revertive returns to primary when it returns
// - toggling nonrevertive does not clear selection
// - device reset or leaving the secondary clears switchover state
// - both lost in automatic mode: holdover, charge pump tristated unless tune voltage is forced to midsupply
// - optional tune voltage forced to midsupply
// - leave holdover when a reference returns
// - a bit disables automatic holdover entry
// - differential receiver off unless selected, loop up
// - single-ended buffers off per three conditions
// - each input differential or single-ended
`timescale 1ns/100ps
`default_nettype none
`include "ref_switch_defines.svh"
module ref_switchover_holdover_ctrl (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // reference samples
  input wire logic primary_ref_input_in,
  input wire logic secondary_ref_input_in,
  // divider settings
  input wire logic [`REF_DIV_WIDTH-1:0] primary_div_in,
  input wire logic [`REF_DIV_WIDTH-1:0] secondary_div_in,
  // selection settings
  input wire logic manual_mode_in,
  input wire logic manual_use_pin_in,
  input wire logic manual_sel_secondary_in,
  input wire logic ref_sel_pin_in,
  input wire logic nonrevertive_in,
  input wire logic holdover_disable_in,
  input wire logic tune_mid_supply_in,
  // receiver settings
  input wire logic loop_power_down_in,
  input wire logic primary_diff_in,
  input wire logic secondary_diff_in,
  input wire logic primary_se_pd_in,
  input wire logic secondary_se_pd_in,
  // to the phase detector
  output logic ref_pulse_out,
  output logic secondary_active_out,
  output logic holdover_out,
  output logic cp_tristate_out,
  output logic cp_force_mid_out,
  // status
  output logic primary_present_out,
  output logic secondary_present_out,
  // receiver power downs
  output logic primary_diff_pd_out,
  output logic secondary_diff_pd_out,
  output logic primary_se_pd_out,
  output logic secondary_se_pd_out
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1;
  logic rst_n;

  // two-stage release so that removal is synchronous to the clock
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ************************************************************
  // dividers and monitors
  // ************************************************************
  logic [1:0] ref_samp;
  logic [1:0] ref_en;
  logic [1:0] pulse;
  logic [1:0] present;
  logic [`REF_DIV_WIDTH-1:0] ratio [2];

  assign ref_samp = {secondary_ref_input_in, primary_ref_input_in};
  assign ratio[0] = primary_div_in;
  assign ratio[1] = secondary_div_in;
  // a receiver that is powered down cannot show a clock to the monitor
  assign ref_en = {~(secondary_diff_pd_out & secondary_se_pd_out),
                   ~(primary_diff_pd_out & primary_se_pd_out)};

  // one divider and monitor per input
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ref
      ref_divider u_div (
        .clk_in(mclk_in),
        .rst_n_in(rst_n),
        .ref_in(ref_samp[gi]),
        .enable_in(ref_en[gi]),
        .ratio_in(ratio[gi]),
        .div_pulse_out(pulse[gi]),
        .present_out(present[gi])
      );
    end
  endgenerate

  // ************************************************************
  // selection state machine
  // ************************************************************
  ref_switch_pkg::sel_state_e state;
  ref_switch_pkg::sel_state_e next_state;
  ref_switch_pkg::sel_state_e auto_dest;
  logic man_sec;
  logic next_sec_active;
  logic next_holdover;
  logic next_ref_pulse;
  logic nonrev_lock;
  logic next_nonrev_lock;

  // manual source: pin or configuration bit
  assign man_sec = manual_use_pin_in ? ref_sel_pin_in : manual_sel_secondary_in;

  // automatic transitions; nonrevertive state survives mode toggling since
  // nonrev_lock holds the move onto the secondary until the machine leaves it
  always_comb begin
    auto_dest = state;
    case (state)
      ref_switch_pkg::SEL_PRIMARY: begin
        if (!present[0] && present[1]) begin
          auto_dest = ref_switch_pkg::SEL_SECONDARY;
        end else if (!present[0] && !present[1] && !holdover_disable_in) begin
          auto_dest = ref_switch_pkg::SEL_HOLDOVER;
        end
      end
      ref_switch_pkg::SEL_SECONDARY: begin
        if (!nonrevertive_in && !nonrev_lock && present[0]) begin
          auto_dest = ref_switch_pkg::SEL_PRIMARY;
        end else if (!present[1] && present[0]) begin
          auto_dest = ref_switch_pkg::SEL_PRIMARY;
        end else if (!present[0] && !present[1] && !holdover_disable_in) begin
          auto_dest = ref_switch_pkg::SEL_HOLDOVER;
        end
      end
      ref_switch_pkg::SEL_HOLDOVER: begin
        if (present[0]) begin
          auto_dest = ref_switch_pkg::SEL_PRIMARY;
        end else if (present[1]) begin
          auto_dest = ref_switch_pkg::SEL_SECONDARY;
        end
      end
      default: auto_dest = ref_switch_pkg::SEL_PRIMARY;
    endcase
  end

  // manual mode overrides automatic moves, holdover entry on loss of both included
  always_comb begin
    next_state = auto_dest;
    if (manual_mode_in) begin
      // host guarantees the chosen input is live before asking for it
      next_state = man_sec ? ref_switch_pkg::SEL_SECONDARY
                           : ref_switch_pkg::SEL_PRIMARY;
    end
    next_sec_active = (next_state == ref_switch_pkg::SEL_SECONDARY);
    next_holdover = (next_state == ref_switch_pkg::SEL_HOLDOVER);
    next_ref_pulse = 1'b0;
    case (state)
      ref_switch_pkg::SEL_PRIMARY: next_ref_pulse = pulse[0];
      ref_switch_pkg::SEL_SECONDARY: next_ref_pulse = pulse[1];
      ref_switch_pkg::SEL_HOLDOVER: next_ref_pulse = 1'b0;
      default: next_ref_pulse = 1'b0;
    endcase
    // an automatic move onto the secondary under nonrevertive mode is latched,
    // so a later toggle of the mode bit cannot pull the selection back
    next_nonrev_lock = nonrev_lock;
    if (next_state != ref_switch_pkg::SEL_SECONDARY) begin
      next_nonrev_lock = 1'b0;
    end else if (state != ref_switch_pkg::SEL_SECONDARY && nonrevertive_in
                 && !manual_mode_in) begin
      next_nonrev_lock = 1'b1;
    end
  end

  // the device reset restores the initial selection and clears the lock
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ref_switch_pkg::SEL_PRIMARY;
      secondary_active_out <= 1'b0;
      holdover_out <= 1'b0;
      ref_pulse_out <= 1'b0;
      nonrev_lock <= 1'b0;
    end else begin
      state <= next_state;
      secondary_active_out <= next_sec_active;
      holdover_out <= next_holdover;
      ref_pulse_out <= next_ref_pulse;
      nonrev_lock <= next_nonrev_lock;
    end
  end

  // ************************************************************
  // charge pump, status and receiver power
  // ************************************************************
  logic next_cp_tri;
  logic next_cp_mid;
  logic next_pdiff_pd;
  logic next_sdiff_pd;
  logic next_pse_pd;
  logic next_sse_pd;

  // receiver power decided from mode settings; lock wait is the host's job
  always_comb begin
    next_cp_tri = next_holdover & ~tune_mid_supply_in;
    next_cp_mid = next_holdover & tune_mid_supply_in;
    next_pdiff_pd = ~primary_diff_in | loop_power_down_in;
    next_sdiff_pd = ~secondary_diff_in | loop_power_down_in;
    next_pse_pd = loop_power_down_in | primary_se_pd_in | primary_diff_in;
    next_sse_pd = loop_power_down_in | secondary_se_pd_in | secondary_diff_in;
  end

  // output registers; receivers start powered down until settings are seen
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cp_tristate_out <= 1'b0;
      cp_force_mid_out <= 1'b0;
      primary_present_out <= 1'b0;
      secondary_present_out <= 1'b0;
      primary_diff_pd_out <= 1'b1;
      secondary_diff_pd_out <= 1'b1;
      primary_se_pd_out <= 1'b1;
      secondary_se_pd_out <= 1'b1;
    end else begin
      cp_tristate_out <= next_cp_tri;
      cp_force_mid_out <= next_cp_mid;
      primary_present_out <= present[0];
      secondary_present_out <= present[1];
      primary_diff_pd_out <= next_pdiff_pd;
      secondary_diff_pd_out <= next_sdiff_pd;
      primary_se_pd_out <= next_pse_pd;
      secondary_se_pd_out <= next_sse_pd;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_both_lost;
    !present[0] && !present[1] && !holdover_disable_in && !manual_mode_in;
  endsequence

  a_holdover_entry: assert property (s_both_lost |=> holdover_out)
    else $error("holdover not entered on loss of both references");
  a_holdover_block: assert property (holdover_disable_in && !holdover_out |=> !holdover_out)
    else $error("holdover entered while disabled");
  a_cp_tristate: assert property (holdover_out && !$past(tune_mid_supply_in) |-> cp_tristate_out)
    else $error("charge pump not tristated in holdover");
  a_cp_mid: assert property (cp_force_mid_out |-> holdover_out && !cp_tristate_out)
    else $error("mid supply forced outside holdover");
  a_auto_switch: assert property (!manual_mode_in && !secondary_active_out
    && !holdover_out && !present[0] && present[1] |=> secondary_active_out)
    else $error("no switch to secondary on primary loss");
  a_revert_back: assert property (!manual_mode_in && !nonrevertive_in && !nonrev_lock
    && secondary_active_out && present[0] |=> !secondary_active_out)
    else $error("revertive mode did not return to primary");
  a_nonrev_stay: assert property (!manual_mode_in && nonrevertive_in
    && secondary_active_out && present[1] |=> secondary_active_out)
    else $error("nonrevertive mode left a live secondary");
  a_nonrev_latch: assert property (!manual_mode_in && nonrev_lock && present[1]
    |=> secondary_active_out)
    else $error("latched nonrevertive selection released");
  a_manual_hold: assert property (manual_mode_in && !manual_use_pin_in
    |=> secondary_active_out == $past(manual_sel_secondary_in))
    else $error("manual selection not followed");
  a_pin_select: assert property (manual_mode_in && manual_use_pin_in
    |=> secondary_active_out == $past(ref_sel_pin_in))
    else $error("select pin not followed");

  // holdover exit is judged one cycle after any monitor reports a live input
  sequence s_ref_back;
    holdover_out && (present[0] || present[1]) && !manual_mode_in;
  endsequence

  a_holdover_exit: assert property (s_ref_back |=> !holdover_out)
    else $error("holdover kept with a live reference");

  // receiver power and the monitor gate
  a_diff_pd: assert property (loop_power_down_in |=> primary_diff_pd_out
    && secondary_diff_pd_out && primary_se_pd_out && secondary_se_pd_out)
    else $error("receiver on while loop powered down");
  a_diff_sel: assert property ((!primary_diff_in |=> primary_diff_pd_out)
    and (!secondary_diff_in |=> secondary_diff_pd_out))
    else $error("differential receiver on while not selected");
  a_se_pd: assert property ((primary_diff_in || primary_se_pd_in |=> primary_se_pd_out)
    and (secondary_diff_in || secondary_se_pd_in |=> secondary_se_pd_out))
    else $error("single-ended buffer on while it should be off");
  a_absent_gate: assert property (primary_diff_pd_out && primary_se_pd_out
    |=> !present[0])
    else $error("primary seen present with its receivers off");
endmodule
`default_nettype wire

/* File: sim/ref_source_model.sv */
// behavioural model of one external reference clock source
`timescale 1ns/100ps
`default_nettype none
module ref_source_model (
  // clock
  input wire logic clk_in,
  // source control
  input wire logic run_in,
  input wire logic [3:0] half_in,
  // reference line
  output logic ref_out = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // toggle every half_in cycles; a stopped source parks low, so no edge reaches the monitor
  always_ff @(posedge clk_in) begin
    if (!run_in) begin
      cnt <= 4'h0;
      ref_out <= 1'b0;
    end else if (cnt == half_in - 4'h1) begin
      cnt <= 4'h0;
      ref_out <= ~ref_out;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/ref_switchover_holdover_ctrl_bench.sv */
// self-checking bench for the reference switchover block
`timescale 1ns/100ps
`default_nettype none
`include "ref_switch_defines.svh"
module ref_switchover_holdover_ctrl_bench;
  logic mclk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic p_run = 1'b1;
  logic s_run = 1'b1;
  logic pri_ref;
  logic sec_ref;
  logic [`REF_DIV_WIDTH-1:0] pri_div = 10'h0001;
  logic [`REF_DIV_WIDTH-1:0] sec_div = 10'h0003;
  logic m_mode = 1'b0;
  logic m_pin = 1'b0;
  logic m_sec = 1'b0;
  logic sel_pin = 1'b0;
  logic nonrev = 1'b0;
  logic ho_dis = 1'b0;
  logic mid = 1'b0;
  logic [4:0] rx = 5'h08; // primary differential, secondary single-ended, both live
  logic ref_pulse, sec_act, hold, cp_tri, cp_mid, p_pres, s_pres;
  logic p_dpd, s_dpd, p_spd, s_spd;
  logic [3:0] st;
  logic [3:0] prev = 4'h0;
  logic [3:0] notes[$];
  logic watch_on = 1'b0;
  logic [15:0] rnd = 16'h506a;
  int n_fail = 0;
  int checks_done = 0;
  int cycles = 0;
  int gap;
  // ten periods of the slowest source before missing presence counts as a failure
  localparam int LOCK_WAIT = 10 * 8;
  assign st = {sec_act, hold, cp_tri, cp_mid};
  always #2.5 mclk_in = ~mclk_in;
  // ************************************************************
  // instances
  // ************************************************************
  ref_source_model src_p (.clk_in(mclk_in), .run_in(p_run), .half_in(4'h3), .ref_out(pri_ref));
  ref_source_model src_s (.clk_in(mclk_in), .run_in(s_run), .half_in(4'h4), .ref_out(sec_ref));
  ref_switchover_holdover_ctrl dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .primary_ref_input_in(pri_ref), .secondary_ref_input_in(sec_ref),
    .primary_div_in(pri_div), .secondary_div_in(sec_div), .manual_mode_in(m_mode),
    .manual_use_pin_in(m_pin), .manual_sel_secondary_in(m_sec), .ref_sel_pin_in(sel_pin),
    .nonrevertive_in(nonrev), .holdover_disable_in(ho_dis), .tune_mid_supply_in(mid),
    .loop_power_down_in(rx[4]), .primary_diff_in(rx[3]), .secondary_diff_in(rx[2]),
    .primary_se_pd_in(rx[1]), .secondary_se_pd_in(rx[0]), .ref_pulse_out(ref_pulse),
    .secondary_active_out(sec_act), .holdover_out(hold), .cp_tristate_out(cp_tri),
    .cp_force_mid_out(cp_mid), .primary_present_out(p_pres), .secondary_present_out(s_pres),
    .primary_diff_pd_out(p_dpd), .secondary_diff_pd_out(s_dpd),
    .primary_se_pd_out(p_spd), .secondary_se_pd_out(s_spd));
  // ************************************************************
  // checking and closing
  // ************************************************************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      n_fail++;
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // every change of the selection outputs consumes the oldest note
  always @(posedge mclk_in) begin
    #1;
    if (watch_on && st !== prev) begin
      if (notes.size() == 0) begin
        check("unexpected_state", st, prev);
      end else begin
        check("sel_state", st, notes.pop_front());
      end
    end
    prev = st;
  end
  // hang guard sized well above the full sequence
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      stop_test();
    end
  end
  // ************************************************************
  // stimulus tasks
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // watch is paused while presence rebuilds after reset
  task automatic do_reset();
    watch_on = 1'b0;
    @(posedge mclk_in);
    arst_n_in <= 1'b0;
    cyc(3);
    arst_n_in <= 1'b1;
    cyc(LOCK_WAIT);
    #1;
    check("state_after_reset", st, 4'h0);
    check("primary_present", p_pres, 1'b1);
    check("secondary_present", s_pres, 1'b1);
    watch_on = 1'b1;
  endtask
  // drive both sources, note the expected change, wait out the loss window
  task automatic refs(input logic p, input logic s, input logic chg, input logic [3:0] v);
    if (chg) notes.push_back(v);
    @(posedge mclk_in);
    p_run <= p;
    s_run <= s;
    cyc(530);
  endtask
  task automatic man(input logic m, input logic up, input logic sel, input logic [3:0] v);
    notes.push_back(v);
    @(posedge mclk_in);
    m_mode <= m;
    m_pin <= up;
    m_sec <= sel;
    sel_pin <= sel;
    cyc(10);
  endtask
  task automatic pulse(output int t);
    t = 0;
    do begin
      @(posedge mclk_in);
      #1;
      t++;
    end while (ref_pulse !== 1'b1 && t < 7000);
  endtask
  // primary toggles every 3 cycles, so a pulse is due every 6 * ratio cycles
  task automatic meas(input logic [9:0] n);
    int k;
    @(posedge mclk_in);
    pri_div <= n;
    pulse(k);
    pulse(k);
    pulse(k);
    check("pulse_gap", k, 6 * n);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    do_reset();
    rnd = lfsr(rnd);
    meas({6'h00, rnd[3:0]} | 10'h0001);
    meas(10'h03ff);
    refs(1'b0, 1'b1, 1'b1, 4'h8);
    // secondary toggles every 4 cycles, so its pulses are 8 * ratio apart
    pulse(gap);
    pulse(gap);
    check("sec_pulse_gap", gap, 8 * sec_div);
    refs(1'b1, 1'b1, 1'b1, 4'h0);
    nonrev <= 1'b1;
    refs(1'b0, 1'b1, 1'b1, 4'h8);
    refs(1'b1, 1'b1, 1'b0, 4'h0);
    nonrev <= 1'b0;
    @(posedge mclk_in);
    nonrev <= 1'b1;
    cyc(20);
    refs(1'b1, 1'b0, 1'b1, 4'h0);
    refs(1'b1, 1'b1, 1'b0, 4'h0);
    refs(1'b0, 1'b1, 1'b1, 4'h8);
    refs(1'b1, 1'b1, 1'b0, 4'h0);
    nonrev <= 1'b0;
    do_reset();
    refs(1'b1, 1'b0, 1'b0, 4'h0);
    refs(1'b0, 1'b0, 1'b1, 4'h6);
    refs(1'b0, 1'b1, 1'b1, 4'h8);
    mid <= 1'b1;
    refs(1'b0, 1'b0, 1'b1, 4'h5);
    refs(1'b1, 1'b0, 1'b1, 4'h0);
    ho_dis <= 1'b1;
    refs(1'b0, 1'b0, 1'b0, 4'h0);
    refs(1'b1, 1'b1, 1'b0, 4'h0);
    ho_dis <= 1'b0;
    // the secondary is live before any manual move onto it
    man(1'b1, 1'b0, 1'b1, 4'h8);
    man(1'b1, 1'b1, 1'b0, 4'h0);
    refs(1'b0, 1'b1, 1'b0, 4'h0);
    man(1'b1, 1'b1, 1'b1, 4'h8);
    man(1'b1, 1'b1, 1'b0, 4'h0);
    man(1'b0, 1'b0, 1'b0, 4'h8);
    refs(1'b1, 1'b1, 1'b1, 4'h0);
    check("notes_left", notes.size(), 0);
    watch_on = 1'b0;
    // receiver power-down decode over random settings
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      @(posedge mclk_in);
      rx <= rnd[4:0];
      cyc(2);
      #1;
      check("pri_diff_pd", p_dpd, !rx[3] || rx[4]);
      check("sec_diff_pd", s_dpd, !rx[2] || rx[4]);
      check("pri_se_pd", p_spd, rx[4] || rx[1] || rx[3]);
      check("sec_se_pd", s_spd, rx[4] || rx[0] || rx[2]);
    end
    stop_test();
  end
endmodule
`default_nettype wire
